// *** testbench/crf_dec_model.sv ***
// Purpose: decoder-side model owning the register write port
// Assumes: bench requests change just after a rising edge
// Notes:   first write after reset loads the stack pointer
module crf_dec_model #(
  parameter logic [31:0] SP_INIT = 32'h00ff_fe00
) (
  input  logic        clk_sys,
  input  logic        sys_rst,
  input  logic        req_en,
  input  logic [2:0]  req_idx,
  input  logic [1:0]  req_size,
  input  logic [1:0]  req_uh,
  input  logic [31:0] req_data,
  output logic        wr_en,
  output logic [2:0]  wr_idx,
  output logic [1:0]  wr_size,
  output logic        wr_upper,
  output logic        wr_hibyte,
  output logic [31:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic init_q;
  // stack load pending until the first edge after reset
  always_ff @(posedge clk_sys or posedge sys_rst)
    if (sys_rst) init_q <= 1'b1;
    else init_q <= 1'b0;
  // longword move into register seven before any other use
  assign wr_en = (init_q & ~sys_rst) | req_en;
  assign wr_idx = init_q ? 3'h7 : req_idx;
  assign wr_size = init_q ? 2'h2 : req_size;
  assign {wr_upper, wr_hibyte} = init_q ? 2'h0 : req_uh;
  assign wr_data = init_q ? SP_INIT : req_data;
endmodule // crf_dec_model

// *** testbench/crf_regfile_asserts.sv ***
// Purpose: concurrent checks on the register file ports
// Assumes: one clock, async active-high reset
// Notes:   bound into the register file after the module
`include "crf_defs.vh"
module crf_chk (
  input logic        clk_sys,
  input logic        sys_rst,
  input logic        reset_vec_load,
  input logic        pc_load,
  input logic [23:0] pc_data,
  input logic [23:0] fetch_addr_q,
  input logic        exc_start,
  input logic        irq_req,
  input logic        nmi_req,
  input logic        irq_accept_q,
  input logic        nmi_accept_q,
  input logic        alu_en,
  input logic        res_en,
  input logic [1:0]  res_size,
  input logic [31:0] res_data,
  input logic        bacc_en,
  input logic        bacc_val,
  input logic [2:0]  flag_op,
  input logic [7:0]  flag_imm,
  input logic [7:0]  flag_reg_q,
  input logic [3:0]  branch_flags_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // no flag source other than flag_op this cycle
  wire idle = !alu_en && !res_en && !bacc_en && !exc_start;

  a_mask_blocks: assert property (irq_req && flag_reg_q[7] |=> !irq_accept_q)
    else $error("irq accepted while masked");
  a_nmi_passes: assert property (nmi_req |=> nmi_accept_q)
    else $error("nmi not accepted");
  a_exc_mask: assert property (exc_start |=> flag_reg_q[7])
    else $error("mask not set on exception");
  a_fetch_even: assert property (fetch_addr_q[0] == 1'b0)
    else $error("odd fetch address");
  a_fetch_follows: assert property (pc_load && !reset_vec_load |=> ##1
    fetch_addr_q[23:1] == $past(pc_data[23:1], 2))
    else $error("fetch address not from pc load");
  a_branch_copy: assert property (branch_flags_q == flag_reg_q[3:0])
    else $error("branch flags differ");
  a_flags_hold: assert property (idle && flag_op == `CRF_FOP_NONE |=> $stable(flag_reg_q))
    else $error("flags changed without cause");
  a_flag_load: assert property (idle && flag_op == `CRF_FOP_LOAD |=> flag_reg_q == $past(flag_imm))
    else $error("flag load wrong");
  a_bit_acc: assert property (bacc_en |=> flag_reg_q[0] == $past(bacc_val))
    else $error("carry not loaded as accumulator");
  a_res_flags: assert property (res_en && !alu_en && res_size == `CRF_SZ_LONG |=>
    flag_reg_q[3:1] == {$past(res_data[31]), $past(res_data) == 32'h0, 1'b0})
    else $error("result flags wrong");

  c_exc: cover property (exc_start);
  c_res: cover property (res_en);
  c_nmi: cover property (nmi_req && flag_reg_q[7]);
endmodule // crf_chk

bind crf_regfile crf_chk crf_chk_inst (.clk_sys, .sys_rst, .reset_vec_load, .pc_load,
  .pc_data, .fetch_addr_q, .exc_start, .irq_req, .nmi_req, .irq_accept_q, .nmi_accept_q,
  .alu_en, .res_en, .res_size, .res_data, .bacc_en, .bacc_val, .flag_op, .flag_imm,
  .flag_reg_q, .branch_flags_q);

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the core register file
// Assumes: 25 MHz clock, reset held 8 cycles
// Notes:   one task per scenario; the model owns the write port
`include "crf_defs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] SP_INIT = 32'h00ff_fe00;
  logic        clk_sys, sys_rst, req_en, wr_en, wr_upper, wr_hibyte;
  logic [2:0]  req_idx, wr_idx, rd_idx, alu_op, flag_op;
  logic [1:0]  req_size, req_uh, wr_size, rd_size, alu_size, res_size;
  logic [31:0] req_data, wr_data, rd_data_q, sp_q, alu_a, alu_b, res_data, alu_result_q;
  logic        rd_upper, rd_hibyte, reset_vec_load, pc_load, exc_start, irq_req, nmi_req;
  logic        irq_accept_q, nmi_accept_q, alu_en, res_en, res_carry_en, res_carry;
  logic        bacc_en, bacc_val;
  logic [23:0] reset_vec, pc_data, fetch_addr_q;
  logic [7:0]  flag_imm, flag_reg_q;
  logic [3:0]  branch_flags_q;
  int          fail_count = 0, n_tests = 0;

  crf_dec_model #(.SP_INIT(SP_INIT)) crf_dec_model_inst (.clk_sys, .sys_rst, .req_en, .req_idx,
    .req_size, .req_uh, .req_data, .wr_en, .wr_idx, .wr_size, .wr_upper, .wr_hibyte, .wr_data);
  crf_regfile crf_regfile_inst (.clk_sys, .sys_rst, .wr_en, .wr_idx, .wr_size, .wr_upper,
    .wr_hibyte, .wr_data, .rd_idx, .rd_size, .rd_upper, .rd_hibyte, .rd_data_q, .sp_q,
    .reset_vec_load, .reset_vec, .pc_load, .pc_data, .fetch_addr_q, .exc_start, .irq_req,
    .nmi_req, .irq_accept_q, .nmi_accept_q, .alu_en, .alu_op, .alu_size, .alu_a, .alu_b,
    .res_en, .res_size, .res_data, .res_carry_en, .res_carry, .bacc_en, .bacc_val, .flag_op,
    .flag_imm, .flag_reg_q, .alu_result_q, .branch_flags_q);

  ////////////////////////////////////////////////////////////
  // 40 ns clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n = 1);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic fl(input logic [2:0] op, input logic [7:0] imm);
    {flag_op, flag_imm} = {op, imm};
    cyc();
    flag_op = `CRF_FOP_NONE;
    cyc(); // idle edge between two flag ops
  endtask
  task automatic wr(input logic [2:0] i, input logic [1:0] s, uh, input logic [31:0] d);
    {req_en, req_idx, req_size, req_uh, req_data} = {1'b1, i, s, uh, d};
    cyc();
    req_en = 1'b0;
    cyc(); // idle edge between two writes
  endtask
  task automatic rd(input logic [2:0] i, input logic [1:0] s, uh, input logic [31:0] e);
    {rd_idx, rd_size, rd_upper, rd_hibyte} = {i, s, uh};
    cyc();
    chk(rd_data_q, e, "read");
  endtask
  task automatic alu(input logic [2:0] op, input logic [1:0] sz, input logic [31:0] a, b,
                     input logic [4:0] e, input logic [7:0] pre = 8'h00);
    logic [31:0] m, r;
    m = (sz == `CRF_SZ_BYTE) ? 32'h0000_00ff : (sz == `CRF_SZ_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
    case (op)
      `CRF_ALU_ADD:  r = a + b;
      `CRF_ALU_ADDX: r = a + b + pre[0];
      `CRF_ALU_SUBX: r = a - b - pre[0];
      `CRF_ALU_NEG:  r = 32'h0000_0000 - b;
      default:       r = a - b;
    endcase
    fl(`CRF_FOP_LOAD, pre);
    {alu_en, alu_op, alu_size, alu_a, alu_b} = {1'b1, op, sz, a, b};
    cyc();
    alu_en = 1'b0;
    chk({flag_reg_q[5], flag_reg_q[3:0]}, e, "alu flags");
    chk(alu_result_q, r & m, "alu result");
  endtask

  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk(flag_reg_q[7], 1'b1, "mask after reset");
    chk(sp_q, SP_INIT, "stack init");
    wr(3'h2, `CRF_SZ_LONG, 2'h0, 32'h1122_3344);
    wr(3'h2, `CRF_SZ_WORD, 2'h2, 32'h0000_aaaa);
    wr(3'h2, `CRF_SZ_BYTE, 2'h0, 32'h0000_0066);
    rd(3'h2, `CRF_SZ_LONG, 2'h0, 32'haaaa_3366);
    rd(3'h2, `CRF_SZ_WORD, 2'h2, 32'h0000_aaaa);
    rd(3'h2, `CRF_SZ_BYTE, 2'h1, 32'h0000_0033);
    wr(3'h7, `CRF_SZ_BYTE, 2'h1, 32'h0000_0055);
    rd(3'h7, `CRF_SZ_LONG, 2'h0, {SP_INIT[31:16], 8'h55, SP_INIT[7:0]});
    chk(sp_q, {SP_INIT[31:16], 8'h55, SP_INIT[7:0]}, "stack copy");
    $display("test regs done");
  endtask
  task automatic t_alu;
    alu(`CRF_ALU_ADD, `CRF_SZ_BYTE, 32'h0f, 32'h01, 5'b10000);
    alu(`CRF_ALU_ADD, `CRF_SZ_WORD, 32'h0fff, 32'h01, 5'b10000);
    alu(`CRF_ALU_ADD, `CRF_SZ_LONG, 32'h0fff_ffff, 32'h01, 5'b10000);
    alu(`CRF_ALU_ADD, `CRF_SZ_BYTE, 32'hff, 32'h01, 5'b10101);
    alu(`CRF_ALU_ADD, `CRF_SZ_BYTE, 32'h7f, 32'h01, 5'b11010);
    alu(`CRF_ALU_SUB, `CRF_SZ_BYTE, 32'h10, 32'h01, 5'b10000);
    alu(`CRF_ALU_CMP, `CRF_SZ_WORD, 32'h00, 32'h01, 5'b11001);
    alu(`CRF_ALU_NEG, `CRF_SZ_LONG, 32'h00, 32'h01, 5'b11001);
    alu(`CRF_ALU_ADDX, `CRF_SZ_BYTE, 32'h01, 32'h01, 5'b00000, 8'h01);
    alu(`CRF_ALU_SUBX, `CRF_SZ_BYTE, 32'h05, 32'h03, 5'b00000, 8'h01);
    alu(`CRF_ALU_SUB, `CRF_SZ_LONG, 32'h00, 32'h00, 5'b00100);
    alu(`CRF_ALU_NEG, `CRF_SZ_BYTE, 32'h00, 32'h80, 5'b01011);
    $display("test alu done");
  endtask
  task automatic t_flags;
    fl(`CRF_FOP_LOAD, 8'h00);
    chk(flag_reg_q, 8'h00, "load");
    fl(`CRF_FOP_OR, 8'h50);
    chk(flag_reg_q, 8'h50, "or");
    fl(`CRF_FOP_XOR, 8'h10);
    chk(flag_reg_q, 8'h40, "xor");
    fl(`CRF_FOP_AND, 8'hc0);
    chk(flag_reg_q, 8'h40, "and");
    exc_start = 1'b1;
    cyc();
    exc_start = 1'b0;
    chk(flag_reg_q, 8'hc0, "exception");
    {bacc_en, bacc_val} = 2'b11;
    cyc(2);
    bacc_en = 1'b0;
    chk(flag_reg_q, 8'hc1, "accumulator");
    {res_en, res_size, res_data, res_carry_en, res_carry} = {1'b1, `CRF_SZ_LONG, 32'h0, 2'b10};
    cyc();
    chk(flag_reg_q, 8'hc4, "zero result");
    {res_size, res_data, res_carry_en} = {`CRF_SZ_BYTE, 32'h0180, 1'b0};
    cyc();
    res_en = 1'b0;
    chk(flag_reg_q, 8'hc8, "byte sign");
    $display("test flags done");
  endtask
  task automatic t_irq_pc;
    fl(`CRF_FOP_LOAD, 8'h00);
    irq_req = 1'b1;
    cyc();
    chk(irq_accept_q, 1'b1, "irq open");
    fl(`CRF_FOP_LOAD, 8'h80);
    cyc();
    chk(irq_accept_q, 1'b0, "irq masked");
    nmi_req = 1'b1;
    cyc();
    chk(nmi_accept_q, 1'b1, "nmi");
    {irq_req, nmi_req, pc_load, pc_data} = {3'b001, 24'h12_3457};
    cyc();
    {reset_vec_load, reset_vec} = {1'b1, 24'h00_0101};
    cyc();
    chk(fetch_addr_q, 24'h12_3456, "fetch even");
    {reset_vec_load, pc_load} = 2'b00;
    cyc();
    chk(fetch_addr_q, 24'h00_0100, "vector");
    $display("test irq pc done");
  endtask
  task automatic t_reset;
    fl(`CRF_FOP_LOAD, 8'h00);
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
    cyc(2);
    chk(flag_reg_q[7], 1'b1, "mask after second reset");
    chk(sp_q, SP_INIT, "stack reloaded");
    $display("test reset done");
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // reset, scenarios, verdict
  initial begin
    sys_rst = 1'b1;
    {req_en, req_idx, req_size, req_uh, req_data, rd_idx, rd_size, rd_upper} = '0;
    {rd_hibyte, reset_vec_load, reset_vec, pc_load, pc_data, exc_start, irq_req, nmi_req} = '0;
    {alu_en, alu_op, alu_size, alu_a, alu_b, res_en, res_size, res_data} = '0;
    {res_carry_en, res_carry, bacc_en, bacc_val, flag_op, flag_imm} = '0;
    cyc(8);
    sys_rst = 1'b0;
    cyc(4);
    t_regs();
    t_alu();
    t_flags();
    t_irq_pc();
    t_reset();
    stop_test();
  end
  // guard against a hang
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    $display("BAD %0t timeout", $time);
    stop_test();
  end
endmodule // testbench

// *** verilog/crf_defs.vh ***
// Purpose: constants for the core register file and flag register
// Assumes: included by bare name from the register file module
// Notes:   bit positions, widths, size codes and operation codes
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH

// flag register bit positions
`define CRF_FLAG_MASK    7
`define CRF_FLAG_UMASK   6
`define CRF_FLAG_HALF    5
`define CRF_FLAG_USER    4
`define CRF_FLAG_NEG     3
`define CRF_FLAG_ZERO    2
`define CRF_FLAG_OVF     1
`define CRF_FLAG_CARRY   0

// widths
`define CRF_DATA_W       32
`define CRF_PC_W         24
`define CRF_FLAG_W       8
`define CRF_NREG         8
`define CRF_SP_INDEX     3'h7

// operand size codes
`define CRF_SZ_BYTE      2'h0
`define CRF_SZ_WORD      2'h1
`define CRF_SZ_LONG      2'h2

// half-carry bit positions per size
`define CRF_HC_BYTE      3
`define CRF_HC_WORD      11
`define CRF_HC_LONG      27

// arithmetic operation codes
`define CRF_ALU_ADD      3'h0
`define CRF_ALU_ADDX     3'h1
`define CRF_ALU_SUB      3'h2
`define CRF_ALU_SUBX     3'h3
`define CRF_ALU_CMP      3'h4
`define CRF_ALU_NEG      3'h5

// flag register operations
`define CRF_FOP_NONE     3'h0
`define CRF_FOP_LOAD     3'h1
`define CRF_FOP_AND      3'h2
`define CRF_FOP_OR       3'h3
`define CRF_FOP_XOR      3'h4

// reset value of the mask bit; other bits are don't care, held at zero
`define CRF_FLAG_RST     8'h80

`endif

// *** verilog/crf_regfile.v ***
// Purpose: architectural register state of the core: eight wide general
//          registers, program counter and flag register with update logic
// Assumes: one clock clk_sys at 25 MHz, asynchronous active-high sys_rst;
//          decoder and ALU are on the same clock and drive one op per cycle
// Notes:   reads are registered, one cycle after the address

`include "crf_defs.vh"

module crf_regfile #(
  parameter DATA_W = `CRF_DATA_W,
  parameter PC_W   = `CRF_PC_W
) (
  input  wire              clk_sys,
  input  wire              sys_rst,
  // general register write port
  input  wire              wr_en,
  input  wire [2:0]        wr_idx,
  input  wire [1:0]        wr_size,
  input  wire              wr_upper,
  input  wire              wr_hibyte,
  input  wire [DATA_W-1:0] wr_data,
  // general register read port
  input  wire [2:0]        rd_idx,
  input  wire [1:0]        rd_size,
  input  wire              rd_upper,
  input  wire              rd_hibyte,
  output reg  [DATA_W-1:0] rd_data_q,
  output reg  [DATA_W-1:0] sp_q,
  // program counter
  input  wire              reset_vec_load,
  input  wire [PC_W-1:0]   reset_vec,
  input  wire              pc_load,
  input  wire [PC_W-1:0]   pc_data,
  output reg  [PC_W-1:0]   fetch_addr_q,
  // exception and interrupt gating
  input  wire              exc_start,
  input  wire              irq_req,
  input  wire              nmi_req,
  output reg               irq_accept_q,
  output reg               nmi_accept_q,
  // arithmetic flag update
  input  wire              alu_en,
  input  wire [2:0]        alu_op,
  input  wire [1:0]        alu_size,
  input  wire [DATA_W-1:0] alu_a,
  input  wire [DATA_W-1:0] alu_b,
  // logic, move or shift result flag update
  input  wire              res_en,
  input  wire [1:0]        res_size,
  input  wire [DATA_W-1:0] res_data,
  input  wire              res_carry_en,
  input  wire              res_carry,
  // bit accumulator
  input  wire              bacc_en,
  input  wire              bacc_val,
  // flag register operations
  input  wire [2:0]        flag_op,
  input  wire [`CRF_FLAG_W-1:0] flag_imm,
  output reg  [`CRF_FLAG_W-1:0] flag_reg_q,
  output reg  [DATA_W-1:0] alu_result_q,
  output reg  [3:0]        branch_flags_q
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // width mask per operand size
  // size code 3 is not used by the decoder and falls into longword
  function [DATA_W-1:0] size_mask;
    input [1:0] sz;
    begin
      case (sz)
        `CRF_SZ_BYTE: size_mask = 32'h0000_00ff;
        `CRF_SZ_WORD: size_mask = 32'h0000_ffff;
        default:      size_mask = 32'hffff_ffff;
      endcase
    end
  endfunction

  // sign bit of a value at the given size
  function sign_of;
    input [1:0]        sz;
    input [DATA_W-1:0] v;
    begin
      case (sz)
        `CRF_SZ_BYTE: sign_of = v[7];
        `CRF_SZ_WORD: sign_of = v[15];
        default:      sign_of = v[31];
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // general registers

  reg [DATA_W-1:0] gpr_q [0:`CRF_NREG-1];
  reg [DATA_W-1:0] lane_mask;
  reg [DATA_W-1:0] lane_data;

  // place write data in the addressed lane
  always @* begin
    lane_mask = 32'hffff_ffff;
    lane_data = wr_data;
    case (wr_size)
      `CRF_SZ_BYTE: begin
        if (wr_hibyte) begin
          lane_mask = 32'h0000_ff00;
          lane_data = {16'h0000, wr_data[7:0], 8'h00};
        end else begin
          lane_mask = 32'h0000_00ff;
          lane_data = {24'h00_0000, wr_data[7:0]};
        end
      end
      `CRF_SZ_WORD: begin
        if (wr_upper) begin
          lane_mask = 32'hffff_0000;
          lane_data = {wr_data[15:0], 16'h0000};
        end else begin
          lane_mask = 32'h0000_ffff;
          lane_data = {16'h0000, wr_data[15:0]};
        end
      end
      default: begin
        lane_mask = 32'hffff_ffff;
        lane_data = wr_data;
      end
    endcase
  end

  // registers carry no reset value; software sets them up
  // leaving out the reset keeps the array free of a wide reset fan-out
  always @(posedge clk_sys) begin
    if (wr_en) begin
      gpr_q[wr_idx] <= (gpr_q[wr_idx] & ~lane_mask) | (lane_data & lane_mask);
    end
  end

  // registered read, selected lane right-justified
  // a write in the same cycle is not forwarded, the read returns the old word
  // upper bits of narrow reads are zero so the datapath needs no extra masking
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= 32'h0000_0000;
      sp_q      <= 32'h0000_0000;
    end else begin
      // stack copy lags register seven by one cycle
      sp_q <= gpr_q[`CRF_SP_INDEX];
      case (rd_size)
        `CRF_SZ_BYTE: rd_data_q <= {24'h00_0000,
                                    rd_hibyte ? gpr_q[rd_idx][15:8] : gpr_q[rd_idx][7:0]};
        `CRF_SZ_WORD: rd_data_q <= {16'h0000,
                                    rd_upper ? gpr_q[rd_idx][31:16] : gpr_q[rd_idx][15:0]};
        default:      rd_data_q <= gpr_q[rd_idx];
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter

  reg [PC_W-1:0] pc_q;

  // vector load outranks a normal load arriving in the same cycle
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q <= 24'h00_0000;
    end else if (reset_vec_load) begin
      pc_q <= reset_vec;
    end else if (pc_load) begin
      pc_q <= pc_data;
    end
  end

  // fetch address with bit 0 forced low
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_addr_q <= 24'h00_0000;
    end else begin
      fetch_addr_q <= {pc_q[PC_W-1:1], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic flag computation

  reg [DATA_W:0]   sum_full;
  reg [DATA_W-1:0] a_m;
  reg [DATA_W-1:0] b_m;
  reg [DATA_W-1:0] op_b;
  reg [DATA_W-1:0] res_m;
  reg              cin;
  reg              is_sub;
  reg              carry_out;
  reg              half_out;
  reg              ovf;
  reg              hc_legal;
  reg [28:0]       low_sum;

  // operands masked to size so stale upper bits cannot reach the flags
  always @* begin
    a_m      = alu_a & size_mask(alu_size);
    b_m      = alu_b & size_mask(alu_size);
    is_sub   = (alu_op == `CRF_ALU_SUB) || (alu_op == `CRF_ALU_SUBX) ||
               (alu_op == `CRF_ALU_CMP) || (alu_op == `CRF_ALU_NEG);
    cin      = ((alu_op == `CRF_ALU_ADDX) || (alu_op == `CRF_ALU_SUBX)) ?
               flag_reg_q[`CRF_FLAG_CARRY] : 1'b0;
    // negate is zero minus the operand in b
    if (alu_op == `CRF_ALU_NEG) begin
      a_m = 32'h0000_0000;
    end
    op_b     = is_sub ? (~b_m & size_mask(alu_size)) : b_m;
    // borrow is the inverse of the adder carry, for both the full and the half flag
    // a - b - c  ==  a + ~b + 1 - c
    sum_full = {1'b0, a_m} + {1'b0, op_b} + {32'h0000_0000, (is_sub ? ~cin : cin)};
    res_m    = sum_full[DATA_W-1:0] & size_mask(alu_size);
    low_sum  = 29'h0000_0000;
    half_out = 1'b0;
    carry_out = 1'b0;
    case (alu_size)
      `CRF_SZ_BYTE: begin
        low_sum   = {24'h00_0000, 1'b0, a_m[3:0]} + {24'h00_0000, 1'b0, op_b[3:0]} +
                    {28'h000_0000, (is_sub ? ~cin : cin)};
        half_out  = low_sum[`CRF_HC_BYTE+1];
        carry_out = sum_full[8];
      end
      `CRF_SZ_WORD: begin
        low_sum   = {16'h0000, 1'b0, a_m[11:0]} + {16'h0000, 1'b0, op_b[11:0]} +
                    {28'h000_0000, (is_sub ? ~cin : cin)};
        half_out  = low_sum[`CRF_HC_WORD+1];
        carry_out = sum_full[16];
      end
      default: begin
        low_sum   = {1'b0, a_m[27:0]} + {1'b0, op_b[27:0]} +
                    {28'h000_0000, (is_sub ? ~cin : cin)};
        half_out  = low_sum[`CRF_HC_LONG+1];
        carry_out = sum_full[32];
      end
    endcase
    // carry into adder means no borrow on subtract
    if (is_sub) begin
      half_out  = ~half_out;
      carry_out = ~carry_out;
    end
    // extend forms exist only for bytes; other sizes leave half carry alone
    hc_legal = !(((alu_op == `CRF_ALU_ADDX) || (alu_op == `CRF_ALU_SUBX)) &&
                 (alu_size != `CRF_SZ_BYTE));
    ovf = (sign_of(alu_size, a_m) == sign_of(alu_size, op_b)) &&
          (sign_of(alu_size, res_m) != sign_of(alu_size, a_m));
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag register

  reg [`CRF_FLAG_W-1:0] flag_d;

  // priority, lowest first: flag op, then alu or result update, then bit accumulator on carry,
  // then exception entry on the mask bit
  // bits 6 and 4 change only through flag ops; bit 6 is left to the interrupt controller
  always @* begin
    flag_d = flag_reg_q;
    case (flag_op)
      `CRF_FOP_LOAD: flag_d = flag_imm;
      `CRF_FOP_AND:  flag_d = flag_reg_q & flag_imm;
      `CRF_FOP_OR:   flag_d = flag_reg_q | flag_imm;
      `CRF_FOP_XOR:  flag_d = flag_reg_q ^ flag_imm;
      default:       flag_d = flag_reg_q;
    endcase
    if (alu_en) begin
      if (hc_legal) begin
        flag_d[`CRF_FLAG_HALF] = half_out;
      end
      flag_d[`CRF_FLAG_NEG]   = sign_of(alu_size, res_m);
      flag_d[`CRF_FLAG_ZERO]  = (res_m == 32'h0000_0000);
      flag_d[`CRF_FLAG_OVF]   = ovf;
      flag_d[`CRF_FLAG_CARRY] = carry_out;
    end else if (res_en) begin
      flag_d[`CRF_FLAG_NEG]  = sign_of(res_size, res_data);
      flag_d[`CRF_FLAG_ZERO] = ((res_data & size_mask(res_size)) == 32'h0000_0000);
      flag_d[`CRF_FLAG_OVF]  = 1'b0;
      if (res_carry_en) begin
        flag_d[`CRF_FLAG_CARRY] = res_carry;
      end
    end
    if (bacc_en) begin
      flag_d[`CRF_FLAG_CARRY] = bacc_val;
    end
    // exception entry wins over any other write to the mask bit
    if (exc_start) begin
      flag_d[`CRF_FLAG_MASK] = 1'b1;
    end
  end

  // reset loads the mask bit set and every other bit clear
  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flag_reg_q <= `CRF_FLAG_RST;
    end else begin
      flag_reg_q <= flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs: result, branch flags, interrupt acceptance

  always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alu_result_q   <= 32'h0000_0000;
      branch_flags_q <= 4'h0;
      irq_accept_q   <= 1'b0;
      nmi_accept_q   <= 1'b0;
    end else begin
      alu_result_q   <= res_m;
      // taken from the next flag value so it lines up with flag_reg_q
      branch_flags_q <= flag_d[`CRF_FLAG_NEG:`CRF_FLAG_CARRY];
      // nmi wins over an irq in the same cycle; the mask bit never holds off nmi
      nmi_accept_q   <= nmi_req;
      irq_accept_q   <= irq_req && !flag_reg_q[`CRF_FLAG_MASK] && !nmi_req;
    end
  end

endmodule // crf_regfile
